// >>> core/vrlvd_consts.svh
// constants for the reference and supply monitor control block
// assumes inclusion by the package and the core module
`ifndef VRLVD_CONSTS_SVH
`define VRLVD_CONSTS_SVH
`define VRLVD_ADDR_REF 8'h9B
`define VRLVD_ADDR_DET 8'h9C
`define VRLVD_ADDR_IRQ_STAT 8'hA0
`define VRLVD_ADDR_IRQ_MASK 8'hA1
`define VRLVD_REF_RESET 8'h00
`define VRLVD_TRIP_RESET 4'h5
`define VRLVD_BIT_HI_EN 7
`define VRLVD_BIT_LO_EN 6
`define VRLVD_BIT_HI_OE 5
`define VRLVD_BIT_LO_OE 4
`define VRLVD_BIT_BANDGAP_STABLE_FLAG 5
`define VRLVD_BIT_DET_EN 4
`define VRLVD_TRIP_EXT 4'hF
`define VRLVD_TRIP_MIN_VALID 4'h4
`define VRLVD_IRQ_LOW_SUPPLY 0
`define VRLVD_IRQ_BG_STABLE 1
`endif

// >>> core/vrlvd_pkg.sv
// types shared by the reference and supply monitor control block
// assumes the constants header sits beside it
`include "vrlvd_consts.svh"
`default_nettype none
package vrlvd_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} vrlvd_bus_t;
	typedef struct packed {
		logic bandgap_on;
		logic high_ref_on;
		logic low_ref_on;
		logic detect_on;
		logic ext_input_sel;
		logic [3:0] trip_level_select;
		logic high_pin_drive;
		logic low_pin_drive;
	} vrlvd_analog_t;
	typedef enum logic [1:0] {
		VRLVD_WAIT = 2'b01,
		VRLVD_ARMED = 2'b10
	} vrlvd_mode_t;
	typedef struct packed {
		logic high_ref_enable;
		logic low_ref_enable;
		logic high_ref_pin_output_enable;
		logic low_ref_pin_output_enable;
		logic detect_power_enable;
		logic [3:0] trip_level_select;
		logic bg_s1;
		logic bg_s2;
		logic low_s1;
		logic low_s2;
		logic bg_prev;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [7:0] rdata;
		logic irq;
		vrlvd_mode_t mode;
		vrlvd_analog_t ana;
	} vrlvd_state_t;
endpackage : vrlvd_pkg
`default_nettype wire

// >>> core/vrlvd_core.sv
// control and status logic for bandgap, references and supply monitor
// assumes a single 250 MHz clock and analog flags already clean of glitches
//
// Design decision made here: the strobed register port.
`include "vrlvd_consts.svh"
`default_nettype none
module vrlvd_core (
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	input wire vrlvd_pkg::vrlvd_bus_t I_BUS,
	input wire logic I_BROWNOUT_RESET_EN,
	input wire logic I_BANDGAP_STABLE,
	input wire logic I_SUPPLY_BELOW_TRIP,
	output logic [7:0] O_RDATA,
	output logic O_IRQ,
	output vrlvd_pkg::vrlvd_analog_t O_ANALOG
);
	import vrlvd_pkg::*;

	vrlvd_state_t st;
	vrlvd_state_t next_st;
	logic [1:0] wr_clear;
	logic [1:0] events;

	always_comb begin
		next_st = st;
		wr_clear = 2'b00;
		events = 2'b00;
		// two stage capture of the analog flags
		next_st.bg_s1 = I_BANDGAP_STABLE;
		next_st.bg_s2 = st.bg_s1;
		next_st.low_s1 = I_SUPPLY_BELOW_TRIP;
		next_st.low_s2 = st.low_s1;
		next_st.bg_prev = st.bg_s2;
		next_st.rdata = 8'h00;
		if (I_BUS.wr) begin
			if (I_BUS.addr == `VRLVD_ADDR_REF) begin
				next_st.high_ref_enable = I_BUS.wdata[`VRLVD_BIT_HI_EN];
				next_st.low_ref_enable = I_BUS.wdata[`VRLVD_BIT_LO_EN];
				next_st.high_ref_pin_output_enable = I_BUS.wdata[`VRLVD_BIT_HI_OE];
				next_st.low_ref_pin_output_enable = I_BUS.wdata[`VRLVD_BIT_LO_OE];
			end else if (I_BUS.addr == `VRLVD_ADDR_DET) begin
				next_st.detect_power_enable = I_BUS.wdata[`VRLVD_BIT_DET_EN];
				next_st.trip_level_select = I_BUS.wdata[3:0];
			end else if (I_BUS.addr == `VRLVD_ADDR_IRQ_STAT) begin
				wr_clear = I_BUS.wdata[1:0];
			end else if (I_BUS.addr == `VRLVD_ADDR_IRQ_MASK) begin
				next_st.irq_mask = I_BUS.wdata[1:0];
			end
		end
		if (I_BUS.rd) begin
			if (I_BUS.addr == `VRLVD_ADDR_REF) begin
				next_st.rdata = {st.high_ref_enable, st.low_ref_enable,
					st.high_ref_pin_output_enable, st.low_ref_pin_output_enable,
					4'h0};
			end else if (I_BUS.addr == `VRLVD_ADDR_DET) begin
				next_st.rdata = {2'b00, st.bg_s2, st.detect_power_enable,
					st.trip_level_select};
			end else if (I_BUS.addr == `VRLVD_ADDR_IRQ_STAT) begin
				next_st.rdata = {6'h00, st.irq_stat};
			end else if (I_BUS.addr == `VRLVD_ADDR_IRQ_MASK) begin
				next_st.rdata = {6'h00, st.irq_mask};
			end
		end
		// detector arms only once the bandgap reports stable
		case (st.mode)
			VRLVD_WAIT: begin
				if (st.detect_power_enable && st.bg_s2) begin
					next_st.mode = VRLVD_ARMED;
				end
			end
			VRLVD_ARMED: begin
				if (!st.detect_power_enable || !st.bg_s2) begin
					next_st.mode = VRLVD_WAIT;
				end
			end
			default: begin
				next_st.mode = VRLVD_WAIT;
			end
		endcase
		events[`VRLVD_IRQ_LOW_SUPPLY] = (st.mode == VRLVD_ARMED) && st.bg_s2 && st.low_s2;
		events[`VRLVD_IRQ_BG_STABLE] = st.bg_s2 && !st.bg_prev;
		// set beats clear; low supply level while armed with bandgap stable also blocks the clear
		next_st.irq_stat = (st.irq_stat & ~wr_clear) | events;
		next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
		next_st.ana.high_ref_on = st.high_ref_enable;
		next_st.ana.low_ref_on = st.low_ref_enable;
		next_st.ana.detect_on = st.detect_power_enable;
		next_st.ana.bandgap_on = I_BROWNOUT_RESET_EN || st.detect_power_enable
			|| st.high_ref_enable || st.low_ref_enable;
		next_st.ana.trip_level_select = st.trip_level_select;
		next_st.ana.ext_input_sel = (st.trip_level_select == `VRLVD_TRIP_EXT);
		next_st.ana.high_pin_drive = st.high_ref_enable
			&& st.high_ref_pin_output_enable;
		next_st.ana.low_pin_drive = st.low_ref_enable
			&& st.low_ref_pin_output_enable;
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st <= '0;
			st.trip_level_select <= `VRLVD_TRIP_RESET;
			st.mode <= VRLVD_WAIT;
		end else begin
			st <= next_st;
		end
	end

	assign O_RDATA = st.rdata;
	assign O_IRQ = st.irq;
	assign O_ANALOG = st.ana;

	logic trip_reserved;
	assign trip_reserved = st.trip_level_select < `VRLVD_TRIP_MIN_VALID;

	sequence low_seen_s;
		st.mode == VRLVD_ARMED && st.bg_s2 && st.low_s2;
	endsequence

	bandgap_power_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		1 |=> O_ANALOG.bandgap_on == ($past(I_BROWNOUT_RESET_EN)
			|| $past(st.detect_power_enable) || $past(st.high_ref_enable)
			|| $past(st.low_ref_enable)))
		else $error("bandgap power does not follow its users");
	detect_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_BUS.wr && I_BUS.addr == `VRLVD_ADDR_DET |=> ##1
		O_ANALOG.detect_on == $past(I_BUS.wdata[`VRLVD_BIT_DET_EN], 2))
		else $error("detect enable write not applied");
	stable_read_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_BUS.rd && I_BUS.addr == `VRLVD_ADDR_DET |=>
		O_RDATA[`VRLVD_BIT_BANDGAP_STABLE_FLAG] == $past(I_BANDGAP_STABLE, 3))
		else $error("stable flag read wrong");
	ext_select_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		O_ANALOG.ext_input_sel |-> O_ANALOG.trip_level_select == `VRLVD_TRIP_EXT)
		else $error("external input chosen for wrong code");
	high_pin_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		O_ANALOG.high_pin_drive |-> O_ANALOG.high_ref_on)
		else $error("high pin driven while reference off");
	low_pin_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		O_ANALOG.low_pin_drive |-> O_ANALOG.low_ref_on)
		else $error("low pin driven while reference off");
	pin_gpio_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		!st.high_ref_enable |=> !O_ANALOG.high_pin_drive)
		else $error("disabled reference still claims pin");
	ref_unused_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_BUS.rd && I_BUS.addr == `VRLVD_ADDR_REF |=> O_RDATA[3:0] == 4'h0)
		else $error("unimplemented bits read nonzero");
	flag_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		!st.bg_s2 && !st.irq_stat[`VRLVD_IRQ_LOW_SUPPLY]
		|=> !st.irq_stat[`VRLVD_IRQ_LOW_SUPPLY])
		else $error("low supply flag set before bandgap stable");
	flag_sticky_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		low_seen_s |=> st.irq_stat[`VRLVD_IRQ_LOW_SUPPLY])
		else $error("low supply flag cleared while supply low");
	sync_delay_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		1 |=> ##1 st.low_s2 == $past(I_SUPPLY_BELOW_TRIP, 2))
		else $error("supply flag not taken through two stages");
	reserved_code_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		trip_reserved |-> !O_ANALOG.ext_input_sel)
		else $error("reserved code treated as external");

	// bus access and bandgap rise shapes shared by the checks below
	sequence ref_write_s;
		I_BUS.wr && I_BUS.addr == `VRLVD_ADDR_REF;
	endsequence
	sequence det_write_s;
		I_BUS.wr && I_BUS.addr == `VRLVD_ADDR_DET;
	endsequence
	sequence ref_read_s;
		I_BUS.rd && I_BUS.addr == `VRLVD_ADDR_REF;
	endsequence
	sequence det_read_s;
		I_BUS.rd && I_BUS.addr == `VRLVD_ADDR_DET;
	endsequence
	sequence stat_read_s;
		I_BUS.rd && I_BUS.addr == `VRLVD_ADDR_IRQ_STAT;
	endsequence
	sequence mask_read_s;
		I_BUS.rd && I_BUS.addr == `VRLVD_ADDR_IRQ_MASK;
	endsequence
	sequence bg_rise_s;
		st.bg_s2 && !st.bg_prev;
	endsequence

	// register writes reach the analog controls two edges later
	high_ref_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		ref_write_s |=> ##1 O_ANALOG.high_ref_on == $past(I_BUS.wdata[`VRLVD_BIT_HI_EN], 2))
		else $error("high reference enable write not applied");
	low_ref_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		ref_write_s |=> ##1 O_ANALOG.low_ref_on == $past(I_BUS.wdata[`VRLVD_BIT_LO_EN], 2))
		else $error("low reference enable write not applied");
	high_oe_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		ref_write_s |=> st.high_ref_pin_output_enable == $past(I_BUS.wdata[`VRLVD_BIT_HI_OE]))
		else $error("high pin output enable write lost");
	low_oe_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		ref_write_s |=> st.low_ref_pin_output_enable == $past(I_BUS.wdata[`VRLVD_BIT_LO_OE]))
		else $error("low pin output enable write lost");
	trip_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		det_write_s |=> st.trip_level_select == $past(I_BUS.wdata[3:0]))
		else $error("trip level write lost");
	mask_write_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_BUS.wr && I_BUS.addr == `VRLVD_ADDR_IRQ_MASK |=> st.irq_mask == $past(I_BUS.wdata[1:0]))
		else $error("interrupt mask write lost");
	ref_keep_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		!(I_BUS.wr && I_BUS.addr == `VRLVD_ADDR_REF) |=> $stable(st.high_ref_enable)
		&& $stable(st.low_ref_enable))
		else $error("reference enables changed without a write");
	det_keep_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		!(I_BUS.wr && I_BUS.addr == `VRLVD_ADDR_DET) |=> $stable(st.trip_level_select)
		&& $stable(st.detect_power_enable))
		else $error("detect control changed without a write");

	// read data path
	ref_read_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		ref_read_s |=> O_RDATA[`VRLVD_BIT_HI_EN] == $past(st.high_ref_enable))
		else $error("high reference enable read wrong");
	det_unused_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		det_read_s |=> O_RDATA[7:6] == 2'b00)
		else $error("unimplemented detect bits read nonzero");
	det_enable_read_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		det_read_s |=> O_RDATA[`VRLVD_BIT_DET_EN] == $past(st.detect_power_enable))
		else $error("detect enable read wrong");
	stable_flag_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		det_read_s |=> O_RDATA[`VRLVD_BIT_BANDGAP_STABLE_FLAG] == $past(st.bg_s2))
		else $error("stable flag read does not match its stage");
	stat_read_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		stat_read_s |=> O_RDATA == {6'h00, $past(st.irq_stat)})
		else $error("status read wrong");
	mask_read_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		mask_read_s |=> O_RDATA == {6'h00, $past(st.irq_mask)})
		else $error("mask read wrong");
	rdata_idle_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		!I_BUS.rd |=> O_RDATA == 8'h00)
		else $error("read data not zero outside a read");

	// bandgap power follows its users
	bandgap_off_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		!I_BROWNOUT_RESET_EN && !st.detect_power_enable && !st.high_ref_enable
		&& !st.low_ref_enable |=> !O_ANALOG.bandgap_on)
		else $error("bandgap powered with no user");
	bor_power_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_BROWNOUT_RESET_EN |=> O_ANALOG.bandgap_on)
		else $error("bandgap off while brown-out enabled");
	detect_power_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		O_ANALOG.detect_on |-> O_ANALOG.bandgap_on)
		else $error("detection on without bandgap");
	high_power_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		O_ANALOG.high_ref_on |-> O_ANALOG.bandgap_on)
		else $error("high reference on without bandgap");
	low_power_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		O_ANALOG.low_ref_on |-> O_ANALOG.bandgap_on)
		else $error("low reference on without bandgap");

	// trip code and pin drive
	ext_code_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		O_ANALOG.trip_level_select == `VRLVD_TRIP_EXT |-> O_ANALOG.ext_input_sel)
		else $error("external code does not select input");
	trip_follow_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		1 |=> O_ANALOG.trip_level_select == $past(st.trip_level_select))
		else $error("trip code not passed to comparator");
	high_pin_on_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		st.high_ref_enable && st.high_ref_pin_output_enable |=> O_ANALOG.high_pin_drive)
		else $error("high pin not driven when asked");
	low_pin_on_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		st.low_ref_enable && st.low_ref_pin_output_enable |=> O_ANALOG.low_pin_drive)
		else $error("low pin not driven when asked");
	low_pin_gpio_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		!st.low_ref_enable |=> !O_ANALOG.low_pin_drive)
		else $error("disabled low reference still claims pin");

	// detector arming, status flags and interrupt
	mode_onehot_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		$onehot(st.mode))
		else $error("detector state not one-hot");
	arm_entry_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		st.mode == VRLVD_WAIT && st.detect_power_enable && st.bg_s2 |=> st.mode == VRLVD_ARMED)
		else $error("detector did not arm");
	disarm_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		st.mode == VRLVD_ARMED && !st.detect_power_enable |=> st.mode == VRLVD_WAIT)
		else $error("detector stayed armed while disabled");
	arm_wait_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		st.mode == VRLVD_WAIT |=> !st.irq_stat[`VRLVD_IRQ_LOW_SUPPLY]
		|| $past(st.irq_stat[`VRLVD_IRQ_LOW_SUPPLY]))
		else $error("low supply flag set while detector not armed");
	clear_works_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		I_BUS.wr && I_BUS.addr == `VRLVD_ADDR_IRQ_STAT && I_BUS.wdata[`VRLVD_IRQ_LOW_SUPPLY]
		&& !(st.mode == VRLVD_ARMED && st.bg_s2 && st.low_s2)
		|=> !st.irq_stat[`VRLVD_IRQ_LOW_SUPPLY])
		else $error("low supply flag not cleared with supply above trip");
	bg_event_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		bg_rise_s |=> st.irq_stat[`VRLVD_IRQ_BG_STABLE])
		else $error("bandgap stable event not recorded");
	sync_bg_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		1 |=> ##1 st.bg_s2 == $past(I_BANDGAP_STABLE, 2))
		else $error("stable flag not taken through two stages");
	irq_level_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		O_IRQ == |(st.irq_stat & st.irq_mask))
		else $error("interrupt level does not follow status and mask");
	irq_quiet_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
		st.irq_mask == 2'b00 && !I_BUS.wr |=> !O_IRQ)
		else $error("interrupt raised with all sources masked");
endmodule : vrlvd_core
`default_nettype wire

// >>> test/vrlvd_analog_model.sv
// analog side model: bandgap start-up timer and supply comparator
// assumes control levels from the block and a low-supply level from the bench
`default_nettype none
module vrlvd_analog_model #(
	parameter int STARTUP = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire vrlvd_pkg::vrlvd_analog_t i_ana,
	input wire logic i_low,
	output logic o_stable,
	output logic o_below
);
	timeunit 1ns;
	timeprecision 1ps;
	import vrlvd_pkg::*;
	int cnt;
	// stable only after power has stood a while
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= 0;
		end else if (!i_ana.bandgap_on) begin
			cnt <= 0;
		end else if (cnt < STARTUP) begin
			cnt <= cnt + 1;
		end
	end
	assign o_stable = (cnt == STARTUP);
	assign o_below = i_ana.detect_on & i_low;
endmodule : vrlvd_analog_model
`default_nettype wire

// >>> test/vref_lvd_control_tb.sv
// bench for the reference and supply monitor control block
// assumes the analog model answers the block's control levels
`default_nettype none
module vref_lvd_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import vrlvd_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic bor = 1'b0;
	logic low = 1'b0;
	logic stable, below, irq;
	logic [7:0] rdata;
	vrlvd_bus_t bus = '0;
	vrlvd_analog_t ana;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	initial begin
		forever #2 clk = ~clk;
	end
	vrlvd_core i_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_BUS(bus),
		.I_BROWNOUT_RESET_EN(bor), .I_BANDGAP_STABLE(stable),
		.I_SUPPLY_BELOW_TRIP(below), .O_RDATA(rdata), .O_IRQ(irq), .O_ANALOG(ana));
	vrlvd_analog_model #(.STARTUP(8)) i_model (.i_clk(clk), .i_rst_n(rst_n),
		.i_ana(ana), .i_low(low), .o_stable(stable), .o_below(below));
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk(11'(rdata), 11'(exp));
		@(posedge clk);
	endtask : rd
	task automatic wait_chk(input int n, input logic [10:0] exp);
		repeat (n) @(posedge clk);
		#1 chk(11'(ana), exp);
		@(posedge clk);
	endtask : wait_chk
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles > 3000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(8'h9B, 8'h00);
		rd(8'h9C, 8'h05);
		rd(8'h55, 8'h00);
		wr(8'h9B, 8'hFF);
		wait_chk(1, {4'hE, 1'b0, 4'h5, 2'b11});
		rd(8'h9B, 8'hF0);
		wr(8'h9B, 8'h30);
		wait_chk(1, {4'h0, 1'b0, 4'h5, 2'b00});
		rd(8'h9B, 8'h30);
		bor <= 1'b1;
		wait_chk(2, {4'h8, 1'b0, 4'h5, 2'b00});
		repeat (16) @(posedge clk);
		rd(8'h9C, 8'h25);
		bor <= 1'b0;
		repeat (8) @(posedge clk);
		rd(8'h9C, 8'h05);
		wr(8'hA1, 8'h01);
		low <= 1'b1;
		wr(8'h9C, 8'hFF);
		wait_chk(1, {4'h9, 1'b1, 4'hF, 2'b00});
		#1 chk(11'(irq), 11'h0);
		@(posedge clk);
		repeat (16) @(posedge clk);
		rd(8'h9C, 8'h3F);
		#1 chk(11'(irq), 11'h1);
		@(posedge clk);
		wr(8'hA0, 8'h01);
		rd(8'hA0, 8'h03);
		low <= 1'b0;
		repeat (8) @(posedge clk);
		wr(8'hA0, 8'h03);
		rd(8'hA0, 8'h00);
		#1 chk(11'(irq), 11'h0);
		@(posedge clk);
		wr(8'h9C, 8'h1E);
		wait_chk(1, {4'h9, 1'b0, 4'hE, 2'b00});
		results();
	end
endmodule : vref_lvd_control_tb
`default_nettype wire
